// ==== core/srpc_defs.vh ====
// How it works
// - general_setup bit 0 picks array type, 0 monochrome, 1 colour; resets 0.
// - variant_info bits 9:8 read 0 on larger variant, 1 on smaller.
// - synth_reset_ctrl bits 3:0 equal to 0x9 hold synthesiser in reset; reset 0x9.
// - synth_reset_ctrl bits 7:4 equal to 0x9 hold lock detector reset; reset 0x9.
// - clockgen_reset_ctrl bits 3:0 equal to 0x9 hold clock generator reset.
// - analog_reset_ctrl bits 3:0 equal to 0x9 hold column multiplexer reset.
// - analog_reset_ctrl bits 7:4 equal to 0x9 hold analog front end reset.
// - analog_reset_ctrl bits 11:8 equal to 0x9 hold serializer reset; register 0x0999.
// - synth_power_ctrl bit 0 low powers synthesiser down; resets to 0.
// - synth_power_ctrl bit 1 high enables the synthesiser; resets to 0.
// - synth_power_ctrl bit 2 high bypasses the synthesiser; resets to 1.
`ifndef SRPC_DEFS_VH
`define SRPC_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SRPC_AW              9
`define SRPC_DW              16
`define SRPC_OFS_IDENT       9'h000
`define SRPC_OFS_VARIANT     9'h001
`define SRPC_OFS_GENERAL     9'h002
`define SRPC_OFS_SYNTH_RST   9'h008
`define SRPC_OFS_CLKGEN_RST  9'h009
`define SRPC_OFS_ANALOG_RST  9'h00a
`define SRPC_OFS_SYNTH_PWR   9'h010
`define SRPC_OFS_SYNTH_TUNE  9'h011

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRPC_GEN_COLOR       0
`define SRPC_GEN_GLOB_LO     2
`define SRPC_GEN_GLOB_HI     3
`define SRPC_VAR_RES_LO      8
`define SRPC_VAR_RES_HI      9
`define SRPC_PWR_PWD_N       0
`define SRPC_PWR_ENABLE      1
`define SRPC_PWR_BYPASS      2
`define SRPC_FIELD_W         4

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SRPC_RST_GENERAL     16'h0000
`define SRPC_RST_SYNTH_RST   16'h0099
`define SRPC_RST_CLKGEN_RST  16'h0009
`define SRPC_RST_ANALOG_RST  16'h0999
`define SRPC_RST_SYNTH_PWR   16'h0004
`define SRPC_RST_SYNTH_TUNE  16'h2113
`define SRPC_VAR_LOW_NIBBLE  4'h1
`define SRPC_SOFT_RST_CODE   4'h9
`define SRPC_IDENT_VALUE     16'h1234 // Arbitrary value, not a real part code
`define SRPC_STRAP_CATCH     2'h2     // Edges after release before strap is caught

`endif

// ==== core/srpc_hold.v ====
`timescale 1ns/100ps
// ----------------------------------------
// Soft-reset field decoder
// ----------------------------------------
`include "srpc_defs.vh"

module srpc_hold (
	input  wire                     clk,     // System clock
	input  wire                     rst_n,   // Synchronised reset, active low
	input  wire [`SRPC_FIELD_W-1:0] field,   // Soft-reset code field
	output reg                      hold_q   // Block held in reset
);

	// Registered compare; reset leaves the block held, as the field resets to the code
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 1'b1;
		end else begin
			hold_q <= (field == `SRPC_SOFT_RST_CODE);
		end
	end

endmodule // srpc_hold

// ==== core/srpc_regs.v ====
`timescale 1ns/100ps
// ----------------------------------------
// Sensor reset and synthesiser register bank
// ----------------------------------------
`include "srpc_defs.vh"

module srpc_regs (
	input  wire                   CLK_SYS,       // 20 MHz system clock
	input  wire                   RESETN,        // Asynchronous reset, active low
	input  wire                   VARIANT_SMALL, // Strap pin, high on smaller variant
	input  wire [`SRPC_AW-1:0]    REG_ADDR,      // Register offset
	input  wire                   REG_WR,        // Write strobe, one cycle
	input  wire [`SRPC_DW-1:0]    REG_WDATA,     // Write data
	input  wire                   REG_RD,        // Read strobe, one cycle
	output reg  [`SRPC_DW-1:0]    REG_RDATA,     // Read data
	output reg                    REG_RVALID,    // Read data valid pulse
	output reg                    COLOR_MODE,    // High for colour array
	output wire                   SYNTH_RST,     // Synthesiser held in reset
	output wire                   LOCKDET_RST,   // Lock detector held in reset
	output wire                   CLKGEN_RST,    // Clock generator held in reset
	output wire                   COLMUX_RST,    // Column multiplexer held in reset
	output wire                   AFE_RST,       // Analog front end held in reset
	output wire                   SER_RST,       // Serializer held in reset
	output reg                    SYNTH_PWD_N,   // Synthesiser powered, high active
	output reg                    SYNTH_EN,      // Synthesiser enable
	output reg                    SYNTH_BYPASS   // Synthesiser bypassed
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function hit;
		input [`SRPC_AW-1:0] addr;
		input [`SRPC_AW-1:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg rst_meta_q;
	reg rst_n_q;

	// Release is synchronous so no flop sees reset leave mid-cycle
	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------
	// Variant strap capture
	// ----------------------------------------
	reg       strap_meta_q;
	reg       strap_sync_q;
	reg [1:0] strap_cnt_q;
	reg       variant_q;

	// Strap is a pin: two flops, caught once the chain holds the pin; later changes ignored
	always @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
			strap_cnt_q  <= 2'h0;
			variant_q    <= 1'b0;
		end else begin
			strap_meta_q <= VARIANT_SMALL;
			strap_sync_q <= strap_meta_q;
			if (strap_cnt_q != 2'h3) begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
			// Catching earlier would take the chain's reset value, not the pin
			if (strap_cnt_q == `SRPC_STRAP_CATCH) begin
				variant_q <= strap_sync_q;
			end
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	reg [`SRPC_DW-1:0] general_q;
	reg [`SRPC_DW-1:0] synth_rst_q;
	reg [`SRPC_DW-1:0] clkgen_rst_q;
	reg [`SRPC_DW-1:0] analog_rst_q;
	reg [`SRPC_DW-1:0] synth_pwr_q;
	reg [`SRPC_DW-1:0] synth_tune_q;

	// Identity and variant offsets have no write path at all
	always @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			general_q    <= `SRPC_RST_GENERAL;
			synth_rst_q  <= `SRPC_RST_SYNTH_RST;
			clkgen_rst_q <= `SRPC_RST_CLKGEN_RST;
			analog_rst_q <= `SRPC_RST_ANALOG_RST;
			synth_pwr_q  <= `SRPC_RST_SYNTH_PWR;
			synth_tune_q <= `SRPC_RST_SYNTH_TUNE;
		end else if (REG_WR) begin
			if (hit(REG_ADDR, `SRPC_OFS_GENERAL)) begin
				// Only colour and pinout bits are stored; the rest read zero
				general_q <= REG_WDATA & 16'h000d;
			end
			if (hit(REG_ADDR, `SRPC_OFS_SYNTH_RST)) begin
				synth_rst_q <= REG_WDATA & 16'h00ff;
			end
			if (hit(REG_ADDR, `SRPC_OFS_CLKGEN_RST)) begin
				clkgen_rst_q <= REG_WDATA & 16'h000f;
			end
			if (hit(REG_ADDR, `SRPC_OFS_ANALOG_RST)) begin
				analog_rst_q <= REG_WDATA & 16'h0fff;
			end
			if (hit(REG_ADDR, `SRPC_OFS_SYNTH_PWR)) begin
				synth_pwr_q <= REG_WDATA & 16'h0007;
			end
			if (hit(REG_ADDR, `SRPC_OFS_SYNTH_TUNE)) begin
				synth_tune_q <= REG_WDATA;
			end
		end
	end

	// ----------------------------------------
	// Read-only values
	// ----------------------------------------
	wire [`SRPC_DW-1:0] ident_val;
	wire [`SRPC_DW-1:0] variant_val;

	// Identity value is arbitrary, not any real part code
	assign ident_val   = `SRPC_IDENT_VALUE;
	assign variant_val = {6'h00, 1'b0, variant_q, 4'h0, `SRPC_VAR_LOW_NIBBLE};

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	reg [`SRPC_DW-1:0] rdata_d;

	// Unmapped offsets read zero
	always @* begin
		rdata_d = 16'h0000;
		case (REG_ADDR)
			`SRPC_OFS_IDENT:      rdata_d = ident_val;
			`SRPC_OFS_VARIANT:    rdata_d = variant_val;
			`SRPC_OFS_GENERAL:    rdata_d = general_q;
			`SRPC_OFS_SYNTH_RST:  rdata_d = synth_rst_q;
			`SRPC_OFS_CLKGEN_RST: rdata_d = clkgen_rst_q;
			`SRPC_OFS_ANALOG_RST: rdata_d = analog_rst_q;
			`SRPC_OFS_SYNTH_PWR:  rdata_d = synth_pwr_q;
			`SRPC_OFS_SYNTH_TUNE: rdata_d = synth_tune_q;
			default:              rdata_d = 16'h0000;
		endcase
	end

	// Data held until the next read so a slow serial port can shift it out
	always @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			REG_RDATA  <= 16'h0000;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rdata_d;
			end
		end
	end

	// ----------------------------------------
	// Control outputs
	// ----------------------------------------
	// Registered copies keep outputs glitch free at the analog boundary
	always @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			COLOR_MODE   <= 1'b0;
			SYNTH_PWD_N  <= 1'b0;
			SYNTH_EN     <= 1'b0;
			SYNTH_BYPASS <= 1'b1;
		end else begin
			COLOR_MODE   <= general_q[`SRPC_GEN_COLOR];
			SYNTH_PWD_N  <= synth_pwr_q[`SRPC_PWR_PWD_N];
			SYNTH_EN     <= synth_pwr_q[`SRPC_PWR_ENABLE];
			SYNTH_BYPASS <= synth_pwr_q[`SRPC_PWR_BYPASS];
		end
	end

	// ----------------------------------------
	// Soft-reset decoders
	// ----------------------------------------
	wire [23:0] fields;
	wire [5:0]  holds;

	// Order: synth, lock detector, clock gen, column mux, front end, serializer
	assign fields = {analog_rst_q[11:8], analog_rst_q[7:4], analog_rst_q[3:0],
	                 clkgen_rst_q[3:0], synth_rst_q[7:4], synth_rst_q[3:0]};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_hold
			srpc_hold u_hold (
				.clk    (CLK_SYS),
				.rst_n  (rst_n_q),
				.field  (fields[gi*4 +: 4]),
				.hold_q (holds[gi])
			);
		end
	endgenerate

	assign SYNTH_RST   = holds[0];
	assign LOCKDET_RST = holds[1];
	assign CLKGEN_RST  = holds[2];
	assign COLMUX_RST  = holds[3];
	assign AFE_RST     = holds[4];
	assign SER_RST     = holds[5];

endmodule // srpc_regs

// ==== sim/srpc_regs_props.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Register bank checker
// ----------------------------------------
module srpc_props (
	input logic        CLK_SYS,      // System clock
	input logic        RESETN,       // Reset, active low
	input logic [8:0]  REG_ADDR,     // Register offset
	input logic        REG_WR,       // Write strobe
	input logic [15:0] REG_WDATA,    // Write data
	input logic        REG_RVALID,   // Read data valid
	input logic        COLOR_MODE,   // Colour array
	input logic        SYNTH_RST,    // Synthesiser hold
	input logic        LOCKDET_RST,  // Lock detector hold
	input logic        CLKGEN_RST,   // Clock generator hold
	input logic        COLMUX_RST,   // Column mux hold
	input logic        AFE_RST,      // Front end hold
	input logic        SER_RST,      // Serializer hold
	input logic        SYNTH_PWD_N,  // Synthesiser powered
	input logic        SYNTH_EN,     // Synthesiser enable
	input logic        SYNTH_BYPASS  // Synthesiser bypass
);
	logic [15:0] wd1_q;
	logic [15:0] wd2_q;

	// Write data two edges back, since outputs trail the register by one edge
	always @(posedge CLK_SYS) begin
		wd1_q <= REG_WDATA;
		wd2_q <= wd1_q;
	end

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	// ----------------------------------------
	// Field to output relations
	// ----------------------------------------
	synth_hold_a: assert property (REG_WR && REG_ADDR == 9'h008 |-> ##2 SYNTH_RST == (wd2_q[3:0] == 4'h9))
		else $error("synthesiser hold wrong");
	lock_hold_a: assert property (REG_WR && REG_ADDR == 9'h008 |-> ##2 LOCKDET_RST == (wd2_q[7:4] == 4'h9))
		else $error("lock detector hold wrong");
	clkgen_hold_a: assert property (REG_WR && REG_ADDR == 9'h009 |-> ##2 CLKGEN_RST == (wd2_q[3:0] == 4'h9))
		else $error("clock generator hold wrong");
	colmux_hold_a: assert property (REG_WR && REG_ADDR == 9'h00a |-> ##2 COLMUX_RST == (wd2_q[3:0] == 4'h9))
		else $error("column mux hold wrong");
	afe_hold_a: assert property (REG_WR && REG_ADDR == 9'h00a |-> ##2 AFE_RST == (wd2_q[7:4] == 4'h9))
		else $error("front end hold wrong");
	ser_hold_a: assert property (REG_WR && REG_ADDR == 9'h00a |-> ##2 SER_RST == (wd2_q[11:8] == 4'h9))
		else $error("serializer hold wrong");
	color_sel_a: assert property (REG_WR && REG_ADDR == 9'h002 |-> ##2 COLOR_MODE == wd2_q[0])
		else $error("array type wrong");
	power_bits_a: assert property (REG_WR && REG_ADDR == 9'h010 |-> ##2 {SYNTH_BYPASS, SYNTH_EN, SYNTH_PWD_N} == wd2_q[2:0])
		else $error("synthesiser control wrong");

	// Main scenarios reached
	cover property (REG_WR && REG_ADDR == 9'h00a);
	cover property (REG_WR && REG_ADDR == 9'h010);
	cover property (REG_RVALID);
endmodule // srpc_props

// ==== sim/srpc_regs_tb.sv ====
`timescale 1ns/100ps
`include "srpc_defs.vh"
module srpc_regs_tb;
	logic        clk_sys, resetn, variant_small, reg_wr, reg_rd;
	logic [8:0]  reg_addr;
	logic [15:0] reg_wdata, sr, cr, ar, gs, pw, tn;
	wire  [15:0] reg_rdata;
	wire         reg_rvalid;
	wire  [9:0]  outs;
	int          errors, tests_run;

	srpc_regs srpc_regs_inst (.CLK_SYS(clk_sys), .RESETN(resetn), .VARIANT_SMALL(variant_small),
		.REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .COLOR_MODE(outs[3]), .SYNTH_RST(outs[9]),
		.LOCKDET_RST(outs[8]), .CLKGEN_RST(outs[7]), .COLMUX_RST(outs[6]), .AFE_RST(outs[5]),
		.SER_RST(outs[4]), .SYNTH_BYPASS(outs[2]), .SYNTH_EN(outs[1]), .SYNTH_PWD_N(outs[0]));

	// 20 MHz clock
	initial begin
		clk_sys = 0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic end_of_test;
		if (errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp(string n, logic [16:0] e, logic [16:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	// Write; the model drops the bits the register does not keep
	// An idle edge first, so back-to-back calls never drop and raise a strobe at once
	task automatic wr(logic [8:0] a, logic [15:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge clk_sys);
		#1 reg_wr = 0;
		case (a)
			9'h002: gs = d & 16'h000d;
			9'h008: sr = d & 16'h00ff;
			9'h009: cr = d & 16'h000f;
			9'h00a: ar = d & 16'h0fff;
			9'h010: pw = d & 16'h0007;
			9'h011: tn = d;
		endcase
	endtask

	// Read; data is valid in the cycle after the strobe
	task automatic rd(logic [8:0] a);
		logic [15:0] e;
		case (a)
			9'h000: e = `SRPC_IDENT_VALUE;
			9'h001: e = variant_small ? 16'h0101 : 16'h0001;
			9'h002: e = gs;
			9'h008: e = sr;
			9'h009: e = cr;
			9'h00a: e = ar;
			9'h010: e = pw;
			9'h011: e = tn;
			default: e = 16'h0000;
		endcase
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_rd = 1;
		@(posedge clk_sys);
		#1 reg_rd = 0;
		cmp("read", {1'b1, e}, {reg_rvalid, reg_rdata});
	endtask

	// Outputs trail a write by one edge
	task automatic chk;
		@(posedge clk_sys);
		#1 cmp("outputs", {sr[3:0] == 4'h9, sr[7:4] == 4'h9, cr[3:0] == 4'h9, ar[3:0] == 4'h9,
			ar[7:4] == 4'h9, ar[11:8] == 4'h9, gs[0], pw[2:0]}, outs);
	endtask

	task automatic do_reset(logic v);
		variant_small = v;
		resetn = 0;
		{gs, sr, cr, ar, pw, tn} = {16'h0000, 16'h0099, 16'h0009, 16'h0999, 16'h0004, 16'h2113};
		repeat (10) @(posedge clk_sys);
		#1 resetn = 1;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [8:0] adr [9] = '{9'h000, 9'h001, 9'h002, 9'h008, 9'h009, 9'h00a, 9'h010, 9'h011, 9'h005};
		foreach (adr[i]) rd(adr[i]);
		chk;
	endtask

	// Codes next to the hold value, back to back with reads
	task automatic t_soft;
		logic [24:0] wl [8] = '{{9'h008, 16'h0089}, {9'h008, 16'hff98}, {9'h009, 16'h0008},
			{9'h009, 16'hfff9}, {9'h00a, 16'h0a98}, {9'h00a, 16'hf89a}, {9'h00a, 16'h0999},
			{9'h011, 16'h5aa5}};
		foreach (wl[i]) begin
			wr(wl[i][24:16], wl[i][15:0]);
			rd(wl[i][24:16]);
			chk;
		end
	endtask

	task automatic t_power;
		for (int i = 0; i < 8; i++) begin
			wr(9'h010, 16'hfff8 | i[15:0]);
			chk;
		end
		wr(9'h002, 16'hffff);
		rd(9'h002);
		chk;
		wr(9'h002, 16'h0000);
		chk;
	endtask

	// Writes to read-only and unmapped places change nothing
	task automatic t_ro;
		wr(9'h000, 16'hffff);
		wr(9'h001, 16'hffff);
		wr(9'h005, 16'hffff);
		rd(9'h000);
		rd(9'h001);
		rd(9'h005);
		chk;
	endtask

	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, errors, tests_run} = 0;
		do_reset(0);
		t_reset;
		t_soft;
		t_power;
		t_ro;
		do_reset(1);
		t_reset;
		end_of_test;
	end

	// Watchdog, far beyond the 155 or so cycles needed
	initial begin
		#(50 * 5000);
		errors++;
		end_of_test;
	end
endmodule // srpc_regs_tb

bind srpc_regs srpc_props srpc_props_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID), .COLOR_MODE(COLOR_MODE),
	.SYNTH_RST(SYNTH_RST), .LOCKDET_RST(LOCKDET_RST), .CLKGEN_RST(CLKGEN_RST), .COLMUX_RST(COLMUX_RST),
	.AFE_RST(AFE_RST), .SER_RST(SER_RST), .SYNTH_PWD_N(SYNTH_PWD_N), .SYNTH_EN(SYNTH_EN),
	.SYNTH_BYPASS(SYNTH_BYPASS));
